// ---- design/uhie_cfg.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit register port, word addressed by byte offset
// Notes: Definitions only
`ifndef UHIE_CFG_SVH
`define UHIE_CFG_SVH
`define UHIE_OFS_IRQ_ENABLE 8'h28
`define UHIE_OFS_FRAME_INDEX 8'h2c
`define UHIE_RST_IRQ_ENABLE 32'h0000_0000
`define UHIE_RST_FRAME_INDEX 32'h0000_0000
`define UHIE_EN_WIDTH 6
`define UHIE_FI_WIDTH 14
`define UHIE_BIT_DONE 0
`define UHIE_BIT_XERR 1
`define UHIE_BIT_PORT 2
`define UHIE_BIT_ROLL 3
`define UHIE_BIT_SERR 4
`define UHIE_BIT_ASYNC 5
`define UHIE_DEFER_MASK 6'h23
`define UHIE_MICROFRAME_NS 125000
`define UHIE_CLK_PERIOD_NS 40
`define UHIE_MICROFRAME_CYC (`UHIE_MICROFRAME_NS / `UHIE_CLK_PERIOD_NS)
`define UHIE_THRESH_DEF 8'h08
`endif

// ---- design/uhie_pkg.sv ----
// Purpose: Types shared by the interrupt-enable and frame-index block
// Assumes: Nothing beyond the cfg header
// Notes: Types only
package uhie_pkg;
    typedef enum logic [1:0] {
        UHIE_RUN = 2'b01,
        UHIE_HALT = 2'b10
    } uhie_state_type;
    typedef logic [13:0] uhie_index_type;
endpackage

// ---- design/uhie_tick.sv ----
// Purpose: Microframe timebase, one pulse per 125 us
// Assumes: Free-running reference clock
// Notes: Counter is held at zero while halted so a restart begins a whole microframe
`timescale 1ns/100ps
module uhie_tick #(
    parameter int CYCLES = 3125
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic run,
    output logic tick_q
);
    logic [15:0] cnt_q;
    wire logic last = (cnt_q == 16'(CYCLES - 1));
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !run) begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= last ? 16'h0000 : cnt_q + 16'h0001;
            tick_q <= last;
        end
    end
endmodule // uhie_tick

// ---- design/uhie_regs.sv ----
// Purpose: Interrupt-enable gating and frame-index counter of a USB host
// Assumes: Single-cycle register port; status events arrive as one-cycle pulses
// Notes: Deferred sources wait for the threshold count of microframes
`timescale 1ns/100ps
`include "uhie_cfg.svh"
module uhie_regs
    import uhie_pkg::*;
#(
    parameter int MICROFRAME_CYC = `UHIE_MICROFRAME_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata_q,
    input wire logic run_stop,
    input wire logic [1:0] list_size_sel,
    input wire logic [7:0] irq_threshold,
    input wire logic [`UHIE_EN_WIDTH-1:0] status_set,
    input wire logic [`UHIE_EN_WIDTH-1:0] status_clr,
    output logic [`UHIE_EN_WIDTH-1:0] status_flags_q,
    output logic halted_flag_q,
    output logic host_irq_q,
    output logic [10:0] sof_frame_q,
    output logic [9:0] list_entry_q,
    output logic microframe_tick_q
);
    logic [`UHIE_EN_WIDTH-1:0] irq_enable_reg_q;
    logic [`UHIE_EN_WIDTH-1:0] irq_enable_reg_d;
    uhie_index_type microframe_counter_q;
    uhie_index_type microframe_counter_d;
    logic [`UHIE_EN_WIDTH-1:0] status_flags_d;
    logic [`UHIE_EN_WIDTH-1:0] pend_q;
    logic [`UHIE_EN_WIDTH-1:0] pend_d;
    logic [7:0] thr_cnt_q;
    logic [7:0] thr_cnt_d;
    uhie_state_type state_q;
    uhie_state_type state_d;
    logic host_irq_d;
    logic [31:0] reg_rdata_d;
    logic halted_flag_d;
    logic [10:0] sof_frame_d;
    logic [9:0] list_entry_d;
    logic tick;
    logic running;

    function automatic logic [9:0] entry_of(input uhie_index_type fi, input logic [1:0] sz);
        case (sz)
            2'b00: entry_of = fi[12:3];
            2'b01: entry_of = {1'b0, fi[11:3]};
            2'b10: entry_of = {2'b00, fi[10:3]};
            default: entry_of = fi[12:3];
        endcase
    endfunction

    assign running = (state_q == UHIE_RUN);

    // Timebase held clear while halted so a restart begins a whole microframe
    uhie_tick #(.CYCLES(MICROFRAME_CYC)) i_uhie_tick (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .run(running),
        .tick_q(tick)
    );

    // Register decode
    wire logic sel_en = (reg_addr == `UHIE_OFS_IRQ_ENABLE);
    wire logic sel_fi = (reg_addr == `UHIE_OFS_FRAME_INDEX);
    wire logic be_full = (reg_be == 4'hf);
    // Byte writes to the index are dropped; only a full word written while halted lands
    wire logic fi_wr = reg_wr && sel_fi && be_full && !running;
    wire logic en_wr = reg_wr && sel_en && reg_be[0];

    // Frame index
    uhie_index_type fi_next;
    assign fi_next = microframe_counter_q + 14'h0001;
    wire logic flip12 = (fi_next[12] != microframe_counter_q[12]);
    wire logic flip13 = (fi_next[13] != microframe_counter_q[13]);
    // Wrap point follows list size for 1024 and 512; size 256 and reserved size wrap as 1024
    wire logic wrap = tick && ((list_size_sel == 2'b01) ? flip12 : flip13);
    assign microframe_counter_d = fi_wr ? reg_wdata[13:0]
        : tick ? fi_next : microframe_counter_q;

    // Status flags
    wire logic [`UHIE_EN_WIDTH-1:0] wrap_bit = wrap ? 6'h08 : 6'h00;
    wire logic [`UHIE_EN_WIDTH-1:0] ev_set = status_set | wrap_bit;
    // Set beats clear so a same-cycle event is kept
    assign status_flags_d = ev_set | (status_flags_q & ~status_clr);

    // Interrupt gating
    wire logic [`UHIE_EN_WIDTH-1:0] gated = status_flags_q & irq_enable_reg_q;
    wire logic thr_zero = (thr_cnt_q == 8'h00);
    wire logic thr_hit = tick && thr_zero;
    // A threshold of zero reloads 255, giving a span of 256 microframes
    assign thr_cnt_d = !tick ? thr_cnt_q : thr_zero ? irq_threshold - 8'h01 : thr_cnt_q - 8'h01;
    wire logic [`UHIE_EN_WIDTH-1:0] thr_take = thr_hit ? gated : 6'h00;
    // Deferred sources latch at threshold and drop once the flag clears
    assign pend_d = (pend_q | thr_take) & gated;
    wire logic [`UHIE_EN_WIDTH-1:0] now_src = gated & ~`UHIE_DEFER_MASK;
    wire logic [`UHIE_EN_WIDTH-1:0] late_src = pend_q & `UHIE_DEFER_MASK;
    assign host_irq_d = |(now_src | late_src);

    // Control
    assign state_d = run_stop ? UHIE_RUN : UHIE_HALT;
    assign irq_enable_reg_d = en_wr ? reg_wdata[`UHIE_EN_WIDTH-1:0] : irq_enable_reg_q;

    // Read path and derived outputs
    wire logic [31:0] en_word = {26'h0, irq_enable_reg_q};
    wire logic [31:0] fi_word = {18'h0, microframe_counter_q};
    wire logic [31:0] rd_mux = sel_en ? en_word : sel_fi ? fi_word : 32'h0000_0000;
    // Idle read data is zero so a stale word never lingers on the bus
    assign reg_rdata_d = reg_rd ? rd_mux : 32'h0000_0000;
    assign halted_flag_d = !running;
    assign sof_frame_d = microframe_counter_q[13:3];
    assign list_entry_d = entry_of(microframe_counter_q, list_size_sel);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q <= UHIE_HALT;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_enable_reg_q <= `UHIE_EN_WIDTH'(`UHIE_RST_IRQ_ENABLE);
        end else begin
            irq_enable_reg_q <= irq_enable_reg_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            microframe_counter_q <= 14'(`UHIE_RST_FRAME_INDEX);
        end else begin
            microframe_counter_q <= microframe_counter_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            status_flags_q <= 6'h00;
        end else begin
            status_flags_q <= status_flags_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pend_q <= 6'h00;
        end else begin
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            thr_cnt_q <= 8'h00;
        end else begin
            thr_cnt_q <= thr_cnt_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            host_irq_q <= 1'b0;
        end else begin
            host_irq_q <= host_irq_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            reg_rdata_q <= 32'h0000_0000;
        end else begin
            reg_rdata_q <= reg_rdata_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            halted_flag_q <= 1'b0;
        end else begin
            halted_flag_q <= halted_flag_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sof_frame_q <= 11'h000;
        end else begin
            sof_frame_q <= sof_frame_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            list_entry_q <= 10'h000;
        end else begin
            list_entry_q <= list_entry_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            microframe_tick_q <= 1'b0;
        end else begin
            microframe_tick_q <= tick;
        end
    end
endmodule // uhie_regs

// ---- test/uhie_regs_chk.sv ----
// Purpose: Port-level assertions for the interrupt-enable and frame-index block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Tick spacing is only judged between ticks of one unbroken run
`timescale 1ns/100ps
module uhie_regs_chk #(
    parameter int MICROFRAME_CYC = 3125
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic run_stop,
    input wire logic [1:0] list_size_sel,
    input wire logic [5:0] status_set,
    input wire logic [5:0] status_clr,
    input wire logic [5:0] status_flags_q,
    input wire logic halted_flag_q,
    input wire logic host_irq_q,
    input wire logic [10:0] sof_frame_q,
    input wire logic [9:0] list_entry_q,
    input wire logic microframe_tick_q
);
    logic [15:0] gap_q;
    logic run_ok_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // A stop restarts the timebase, so the gap after it is not judged
    always_ff @(posedge ref_clk) begin
        gap_q <= (!rst_b || microframe_tick_q) ? 16'h0000 : gap_q + 16'h0001;
        run_ok_q <= rst_b && run_stop && (microframe_tick_q || run_ok_q);
    end
    a_halt_run_low: assert property (run_stop [*3] |=> !halted_flag_q)
        else $error("halted flag high while running");
    a_halt_stop_high: assert property (!run_stop [*3] |=> halted_flag_q)
        else $error("halted flag low after stop");
    a_flag_set_seen: assert property (|status_set |=>
        (status_flags_q & $past(status_set)) == $past(status_set)) else $error("flag not set");
    a_flag_clear_done: assert property (|status_clr |=>
        (status_flags_q & $past(status_clr & ~status_set)) == 6'h00) else $error("flag kept");
    a_irq_has_cause: assert property (host_irq_q |->
        |($past(status_flags_q) | $past(status_flags_q, 2))) else $error("irq without flag");
    a_list_entry_bits: assert property (list_entry_q ==
        (($past(list_size_sel) == 2'b01) ? {1'b0, sof_frame_q[8:0]}
        : ($past(list_size_sel) == 2'b10) ? {2'b00, sof_frame_q[7:0]}
        : sof_frame_q[9:0])) else $error("list entry bits wrong");
    a_tick_spacing: assert property (microframe_tick_q && run_ok_q |->
        gap_q == MICROFRAME_CYC - 1) else $error("microframe tick spacing wrong");
    a_sof_on_tick: assert property (run_stop [*4] ##1 $changed(sof_frame_q) |->
        $past(microframe_tick_q) || $past(microframe_tick_q, 2) || $past(microframe_tick_q, 3))
        else $error("frame number moved without tick");
endmodule // uhie_regs_chk
bind uhie_regs uhie_regs_chk #(.MICROFRAME_CYC(MICROFRAME_CYC)) i_uhie_regs_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .run_stop(run_stop), .list_size_sel(list_size_sel),
    .status_set(status_set), .status_clr(status_clr), .status_flags_q(status_flags_q),
    .halted_flag_q(halted_flag_q), .host_irq_q(host_irq_q), .sof_frame_q(sof_frame_q),
    .list_entry_q(list_entry_q), .microframe_tick_q(microframe_tick_q));

// ---- test/test_usb_host_irq_enable_frame_index.sv ----
// Purpose: Self-checking bench for the interrupt-enable and frame-index block
// Assumes: Short microframe of 10 cycles, inputs driven on the falling edge
// Notes: Read data is checked from a queue by a separate monitor
`timescale 1ns/100ps
module test_usb_host_irq_enable_frame_index;
    logic ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run_stop = 1'b0;
    logic rd_dly = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [3:0] reg_be = 4'h0;
    logic [31:0] reg_wdata = 32'h0, r, reg_rdata_q;
    logic [1:0] list_size_sel = 2'h0;
    logic [5:0] status_set = 6'h00, status_clr = 6'h00, status_flags_q;
    logic halted_flag_q, host_irq_q, microframe_tick_q;
    logic [10:0] sof_frame_q;
    logic [9:0] list_entry_q;
    logic [31:0] exp_q[$];
    int error_cnt = 0, checks_done = 0;
    uhie_regs #(.MICROFRAME_CYC(10)) i_uhie_regs (.ref_clk(ref_clk), .rst_b(rst_b),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .run_stop(run_stop),
        .list_size_sel(list_size_sel), .irq_threshold(8'h02), .status_set(status_set),
        .status_clr(status_clr), .status_flags_q(status_flags_q), .halted_flag_q(halted_flag_q),
        .host_irq_q(host_irq_q), .sof_frame_q(sof_frame_q), .list_entry_q(list_entry_q),
        .microframe_tick_q(microframe_tick_q));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(negedge ref_clk);
        {reg_wr, reg_addr, reg_wdata, reg_be} = {1'b1, a, d, be};
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge ref_clk);
        {reg_rd, reg_addr} = {1'b1, a};
        exp_q.push_back(e);
        @(negedge ref_clk);
        reg_rd = 1'b0;
    endtask
    // Three idle edges leave room for the registered flag and interrupt stages
    task automatic pulse(input logic [5:0] s, input logic [5:0] c);
        @(negedge ref_clk);
        {status_set, status_clr} = {s, c};
        @(negedge ref_clk);
        {status_set, status_clr} = 12'h000;
        repeat (3) @(negedge ref_clk);
    endtask
    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) rd_dly <= reg_rd;
    always @(negedge ref_clk) if (rd_dly) chk("rdata", reg_rdata_q, exp_q.pop_front());
    initial begin
        #160000;
        error_cnt++;
        end_sim;
    end
    initial begin
        void'($urandom(32'h6e3b));
        repeat (10) @(negedge ref_clk);
        rst_b = 1'b1;
        rd(8'h28, 32'h0);
        rd(8'h2c, 32'h0);
        rd(8'h30, 32'h0);
        r = $urandom & 32'h3f;
        wr(8'h28, r, 4'hf);
        rd(8'h28, r);
        wr(8'h28, 32'h3b, 4'hf);
        wr(8'h2c, 32'h1ff8, 4'h1);
        rd(8'h2c, 32'h0);
        wr(8'h2c, 32'h1ff8, 4'hf);
        rd(8'h2c, 32'h1ff8);
        chk("sof", sof_frame_q, 32'h3ff);
        pulse(6'h14, 6'h00);
        chk("flags", status_flags_q, 32'h14);
        chk("irq", host_irq_q, 32'h1);
        pulse(6'h00, 6'h10);
        chk("irq", host_irq_q, 32'h0);
        run_stop = 1'b1;
        repeat (100) @(negedge ref_clk);
        chk("rollover", status_flags_q[3], 32'h1);
        chk("irq", host_irq_q, 32'h1);
        chk("sof", sof_frame_q, 32'h400);
        chk("halted", halted_flag_q, 32'h0);
        wr(8'h2c, 32'h0, 4'hf);
        chk("sof", sof_frame_q, 32'h400);
        pulse(6'h00, 6'h08);
        chk("irq", host_irq_q, 32'h0);
        list_size_sel = 2'b01;
        pulse(6'h01, 6'h00);
        for (int i = 0; i < 60 && host_irq_q !== 1'b1; i++) @(negedge ref_clk);
        chk("irq", host_irq_q, 32'h1);
        pulse(6'h00, 6'h01);
        chk("irq", host_irq_q, 32'h0);
        pulse(6'h22, 6'h00);
        for (int i = 0; i < 60 && host_irq_q !== 1'b1; i++) @(negedge ref_clk);
        chk("irq", host_irq_q, 32'h1);
        pulse(6'h00, 6'h20);
        chk("irq", host_irq_q, 32'h1);
        pulse(6'h00, 6'h02);
        chk("irq", host_irq_q, 32'h0);
        wr(8'h28, 32'h3f, 4'hf);
        repeat (2) @(negedge ref_clk);
        chk("irq", host_irq_q, 32'h1);
        pulse(6'h00, 6'h04);
        chk("irq", host_irq_q, 32'h0);
        run_stop = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("halted", halted_flag_q, 32'h1);
        wr(8'h2c, 32'h3ff8, 4'hf);
        rd(8'h2c, 32'h3ff8);
        repeat (2) @(negedge ref_clk);
        chk("entry", list_entry_q, 32'h1ff);
        list_size_sel = 2'b10;
        repeat (2) @(negedge ref_clk);
        chk("entry", list_entry_q, 32'h0ff);
        list_size_sel = 2'b11;
        repeat (2) @(negedge ref_clk);
        chk("entry", list_entry_q, 32'h3ff);
        chk("sof", sof_frame_q, 32'h7ff);
        end_sim;
    end
endmodule // test_usb_host_irq_enable_frame_index
